/* verification/fabric_source.sv */
`timescale 1ns/1ps
// Fabric-side word source: offers queued words and holds each one unchanged until the design takes it.
module fabric_source (
  input  wire logic        sys_clk_in,   // Shared fabric clock.
  input  wire logic        ready_in,     // Design accepts a word this cycle.
  output logic             valid_out,    // Word offered.
  output logic [19:0]      data_out,     // Lane 0 in [9:0], lane 1 in [19:10].
  output logic [1:0]       ctrl_out,     // Control flag per lane.
  output logic [1:0]       force_out,    // Disparity override per lane.
  output logic [1:0]       dispval_out,  // Override value per lane.
  output int               taken_out     // Words taken so far.
);
  logic [25:0] q[$];  // Pending entries as dispval, force, ctrl, data.
  logic        took;  // The offered word was taken at the last rising edge.

  // Start idle with a defined bus.
  initial begin
    valid_out = 1'h0;
    data_out = 20'h00000;
    ctrl_out = 2'h0;
    force_out = 2'h0;
    dispval_out = 2'h0;
    taken_out = 0;
    took = 1'h0;
  end

  // Acceptance is judged at the rising edge, before the design's own updates land.
  always @(posedge sys_clk_in) begin
    took = valid_out && ready_in;
    if (took) begin
      taken_out++;
    end
  end

  // Bus signals move only at the falling edge; an idle bus shows inverted data so a stray capture is visible.
  always @(negedge sys_clk_in) begin
    if (took && q.size() > 0) begin
      void'(q.pop_front());
    end
    took = 1'h0;
    if (q.size() > 0) begin
      valid_out = 1'h1;
      {dispval_out, force_out, ctrl_out, data_out} = q[0];
    end else begin
      valid_out = 1'h0;
      data_out = ~data_out;
    end
  end
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [7:0] d; logic [2:0] cfv; logic [9:0] e;} enc_row_t;
  typedef struct packed {logic [1:0] w; logic [2:0] o; logic [3:0] s; logic [19:0] d; logic [9:0] e0, e1;} byp_row_t;

  logic        sys_clk_in;     // Shared clock, 5 ns period.
  logic        rst_in;         // Power-on reset.
  logic        pcs_reset_in;   // Logic reset of the transmit path.
  logic [1:0]  width_sel_in;   // Fabric width code.
  logic        enc_enable_in;  // Encoder in use.
  logic        reg_mode_in;    // Registered FIFO mode.
  logic        bit_flip_in;    // Per-byte bit flip.
  logic        bit_rev_in;     // Word bit reversal.
  logic        pol_inv_in;     // Polarity inversion.
  logic [3:0]  slip_count_in;  // Transmit slip in bits.
  logic        tx_valid_in;    // Driven by the source model.
  logic [19:0] tx_data_in;     // Driven by the source model.
  logic [1:0]  tx_ctrl_in;     // Driven by the source model.
  logic [1:0]  tx_force_in;    // Driven by the source model.
  logic [1:0]  tx_dispval_in;  // Driven by the source model.
  logic        tx_ready_out;   // FIFO accepts a word.
  logic [1:0]  ser_bits_out;   // Two serial bits per cycle.
  logic        word_tick_out;  // Word load marker.
  int          taken;          // Words taken by the design.
  int          n_errors;       // Mismatches seen.
  int          n_checks;       // Comparisons made.
  int          i, k, m, n, t0; // Scratch counters.
  logic [9:0]  acc;            // Serial bits gathered, earliest at the bottom.
  logic [9:0]  words[$];       // Words rebuilt from the serial stream.
  logic        wide10;         // Serializer word is 10 bits.

  // Ctrl, force and dispval per row; control is raised only on the comma byte.
  enc_row_t enc_rows [8] = '{'{8'h00, 3'h0, 10'h346}, '{8'h00, 3'h0, 10'h346}, '{8'hbc, 3'h0, 10'h15c},
    '{8'hbc, 3'h4, 10'h283}, '{8'hbc, 3'h6, 10'h283}, '{8'hbc, 3'h4, 10'h17c}, '{8'hbc, 3'h7, 10'h17c},
    '{8'hb5, 3'h0, 10'h155}};
  // Width code, options flip/rev/inv, slip, data, first and second word; wide rows need the byte serializer.
  // Inversion only changes under the logic reset; a live receiver absorbs the disparity slip of a change.
  byp_row_t byp_rows [10] = '{'{2'h0, 3'h0, 4'h0, 20'h0002d, 10'h02d, 10'h000},
    '{2'h0, 3'h4, 4'h0, 20'h0002d, 10'h0b4, 10'h000}, '{2'h0, 3'h2, 4'h0, 20'h0002d, 10'h0b4, 10'h000},
    '{2'h0, 3'h1, 4'h0, 20'h0002d, 10'h0d2, 10'h0ff}, '{2'h0, 3'h0, 4'h3, 20'h0002d, 10'h068, 10'h001},
    '{2'h1, 3'h0, 4'h0, 20'h002d5, 10'h2d5, 10'h000}, '{2'h1, 3'h2, 4'h0, 20'h002d5, 10'h2ad, 10'h000},
    '{2'h1, 3'h4, 4'h0, 20'h002d5, 10'h2ab, 10'h000}, '{2'h2, 3'h4, 4'h0, 20'h2f0ad, 10'h0b5, 10'h03d},
    '{2'h3, 3'h0, 4'h0, 20'h68ed5, 10'h2d5, 10'h1a3}};

  serial_tx_pcs #(.DEPTH(serial_tx_pcs_pkg::FIFO_DEPTH)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .pcs_reset_in(pcs_reset_in), .width_sel_in(width_sel_in), .enc_enable_in(enc_enable_in),
    .reg_mode_in(reg_mode_in), .bit_flip_in(bit_flip_in), .bit_rev_in(bit_rev_in), .pol_inv_in(pol_inv_in),
    .slip_count_in(slip_count_in), .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in), .tx_ctrl_in(tx_ctrl_in),
    .tx_force_in(tx_force_in), .tx_dispval_in(tx_dispval_in), .tx_ready_out(tx_ready_out),
    .ser_bits_out(ser_bits_out), .word_tick_out(word_tick_out));

  fabric_source src (.sys_clk_in(sys_clk_in), .ready_in(tx_ready_out), .valid_out(tx_valid_in),
    .data_out(tx_data_in), .ctrl_out(tx_ctrl_in), .force_out(tx_force_in), .dispval_out(tx_dispval_in),
    .taken_out(taken));

  // The clock toggles every half period.
  initial sys_clk_in = 1'h0;
  always #2.5 sys_clk_in = ~sys_clk_in;

  // Rebuild words from the stream; the tick cycle still shows the last pair of the finished word.
  always @(negedge sys_clk_in) begin
    acc = {ser_bits_out, acc[9:2]};
    if (word_tick_out === 1'h1) begin
      words.push_back(wide10 ? acc : {2'h0, acc[9:2]});
    end
  end

  // Compares one value and reports a difference at once.
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Waits a bounded time for enough rebuilt words; a stall ends the run.
  task automatic wait_words(input int want);
    int c;
    c = 0;
    while (words.size() < want && c < 500) begin
      @(negedge sys_clk_in);
      c++;
    end
    if (c >= 500) begin
      n_errors++;
      $display("MISMATCH word_count expected %0d seen %0d", want, words.size());
      give_verdict();
    end
  endtask

  // Modes change only under the logic reset; refusal, and in encoder starts the reset commas, are checked before release.
  task automatic start(input logic [1:0] w, input logic enc, input logic rm, input logic [2:0] o,
                       input logic [3:0] sl);
    @(negedge sys_clk_in);
    pcs_reset_in = 1'h1;
    width_sel_in = w;
    enc_enable_in = enc;
    reg_mode_in = rm;
    {bit_flip_in, bit_rev_in, pol_inv_in} = o;
    slip_count_in = sl;
    wide10 = enc | w[0];
    src.q.delete();
    repeat (15) @(negedge sys_clk_in);
    words.delete();
    repeat (10) @(negedge sys_clk_in);
    check("ready_in_reset", {9'h000, tx_ready_out}, 10'h000);
    if (enc) begin
      foreach (words[j]) check("reset_comma", words[j], serial_tx_pcs_pkg::COMMA_RDN);
    end
  endtask

  initial begin
    {rst_in, pcs_reset_in, width_sel_in, enc_enable_in, reg_mode_in} = 6'h30;
    {bit_flip_in, bit_rev_in, pol_inv_in, slip_count_in} = 7'h00;
    {acc, wide10, n_errors, n_checks} = '0;
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'h0;
    // Encoder rows queued while refused, then released: three sync commas and the table follow.
    start(2'h0, 1'h1, 1'h0, 3'h0, 4'h0);
    foreach (enc_rows[r]) src.q.push_back({1'h0, enc_rows[r].cfv[0], 1'h0, enc_rows[r].cfv[1],
                                           1'h0, enc_rows[r].cfv[2], 12'h000, enc_rows[r].d});
    pcs_reset_in = 1'h0;
    wait_words(20);
    i = 1;
    while (i < 10 && words[i] !== 10'h283) i++;
    check("sync_first", words[i - 1], serial_tx_pcs_pkg::COMMA_RDN);
    check("sync_second", words[i], 10'h283);
    check("sync_third", words[i + 1], serial_tx_pcs_pkg::COMMA_RDN);
    foreach (enc_rows[r]) check("enc_word", words[i + 2 + r], enc_rows[r].e);
    // Bypass rows: one word each, found as the first word that differs from the idle fill.
    foreach (byp_rows[r]) begin
      start(byp_rows[r].w, 1'h0, 1'h0, byp_rows[r].o, byp_rows[r].s);
      src.q.push_back({6'h00, byp_rows[r].d});
      pcs_reset_in = 1'h0;
      // Drop the reset commas and the slipped tail of the last one before looking for the word.
      n = 0;
      k = 0;
      while (n < 3 && k < 40) begin
        @(negedge sys_clk_in);
        k++;
        if (word_tick_out === 1'h1) begin
          n++;
        end
      end
      check("byp_ticks", n[9:0], 10'h003);
      @(posedge sys_clk_in);
      words.delete();
      wait_words(14);
      i = 0;
      while (i < 12 && words[i] === (byp_rows[r].o[0] ? (wide10 ? 10'h3ff : 10'h0ff) : 10'h000)) i++;
      check("byp_first", words[i], byp_rows[r].e0);
      check("byp_second", words[i + 1], byp_rows[r].e1);
    end
    // Continuous offers fill the FIFO; at most one pop can fall inside the filling burst.
    for (m = 0; m < 2; m++) begin
      start(2'h1, 1'h0, m[0], 3'h0, 4'h0);
      repeat (12) src.q.push_back(26'h00002d5);
      pcs_reset_in = 1'h0;
      t0 = taken;
      k = 0;
      do begin
        @(negedge sys_clk_in);
        k++;
      end while (k < 20 && tx_ready_out === 1'h1);
      n = taken - t0;
      i = m ? serial_tx_pcs_pkg::REG_MODE_DEPTH : serial_tx_pcs_pkg::FIFO_DEPTH;
      check("fifo_full", {9'h000, tx_ready_out}, 10'h000);
      check("fifo_taken", {9'h000, (n == i || n == i + 1)}, 10'h001);
    end
    give_verdict();
  end
endmodule

/* verilog/serial_tx_pcs.sv */
`timescale 1ns/1ps
module serial_tx_pcs #(
  parameter int unsigned DEPTH = serial_tx_pcs_pkg::FIFO_DEPTH
) (
  input  wire logic        sys_clk_in,       // Parallel and fabric clock.
  input  wire logic        rst_in,           // Asynchronous power-on reset, active high.
  input  wire logic        pcs_reset_in,     // Synchronous logic reset of the transmit path.
  input  wire logic [1:0]  width_sel_in,     // Fabric width, see width_sel_t.
  input  wire logic        enc_enable_in,    // Encoder in use.
  input  wire logic        reg_mode_in,      // Deterministic-latency registered FIFO.
  input  wire logic        bit_flip_in,      // Reverse bits within each fabric byte.
  input  wire logic        bit_rev_in,       // Send most significant bit first.
  input  wire logic        pol_inv_in,       // Invert every serialized bit.
  input  wire logic [3:0]  slip_count_in,    // Bits of transmit delay.
  input  wire logic        tx_valid_in,      // Fabric word offered.
  input  wire logic [19:0] tx_data_in,       // Lane 0 in [9:0], lane 1 in [19:10].
  input  wire logic [1:0]  tx_ctrl_in,       // Control flag per lane.
  input  wire logic [1:0]  tx_force_in,      // Disparity override per lane.
  input  wire logic [1:0]  tx_dispval_in,    // Override value per lane.
  output logic             tx_ready_out,     // FIFO accepts a word this cycle.
  output logic [1:0]       ser_bits_out,     // Bit 0 on rising edge, bit 1 on falling edge.
  output logic             word_tick_out     // Pulse in the cycle a new word is loaded.
);

  // One FIFO entry carries a full fabric word with its per-lane flags.
  localparam int unsigned ENTRY_W = 26;
  localparam int unsigned PTR_W   = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Storage and occupancy of the phase-compensation FIFO.
  logic [ENTRY_W-1:0] fifo_mem [DEPTH];
  logic [PTR_W-1:0]   wr_ptr_q;
  logic [PTR_W-1:0]   rd_ptr_q;
  logic [PTR_W:0]     fifo_count_q;
  logic [PTR_W:0]     fifo_limit;     // Capacity allowed by the current mode.
  logic               push;
  logic               pop;
  logic [ENTRY_W-1:0] head;
  logic [19:0]        flipped;        // Fabric data after the optional byte bit-flip.

  // Byte serializer and lane register.
  logic               byte_ser;       // Wide fabric word in use.
  logic               half_q;         // Second lane of the held wide word is next.
  logic [12:0]        wide_hi_q;      // Upper lane kept for the second word period.
  logic [9:0]         lane_d_q;
  logic               lane_k_q;
  logic               lane_f_q;
  logic               lane_v_q;
  logic               lane_vld_q;
  logic               lane_stall;     // Lane stage waits while the first sync commas go out.

  // Encoder state.
  logic [9:0]         enc_q;          // Word handed to the bit-level options.
  logic               rd_q;           // Running disparity, high when positive.
  logic [1:0]         sync_q;         // Comma groups still to send.
  logic [10:0]        enc_res;

  // Serializer state.
  logic               wide_pma;       // Ten-bit serializer word.
  logic [3:0]         word_bits;
  logic [2:0]         cnt_q;
  logic               tick;
  logic [9:0]         prev_q;         // Last word after reversal, for bit slip.
  logic [9:0]         rev_word;
  logic [9:0]         ser_word;
  logic [9:0]         shift_q;

  // Reverse the low n bits of a ten-bit word.
  function automatic logic [9:0] reverse_bits(input logic [9:0] w, input logic [3:0] n);
    logic [9:0] r;
    r = 10'h000;
    for (int i = 0; i < 10; i++) begin
      if (i < int'(n)) begin
        r[i] = w[int'(n) - 1 - i];
      end
    end
    return r;
  endfunction

  // Encode a byte into a code group; returns the new disparity above the code, bit 0 sent first.
  function automatic logic [10:0] encode_group(input logic [7:0] d, input logic k, input logic rd_pos);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s6;
    logic [3:0] s4;
    logic       rd6;
    logic       alt;
    logic [9:0] s;
    x = d[4:0];
    y = d[7:5];
    s6 = serial_tx_pcs_pkg::SIX_RDN[x];
    s4 = serial_tx_pcs_pkg::FOUR_D_RDN[y];
    rd6 = rd_pos;
    alt = 1'b0;
    if (k) begin
      // Control groups are whole complements between the two columns.
      s = (x == 5'h1c) ? {serial_tx_pcs_pkg::SIX_K28, serial_tx_pcs_pkg::FOUR_K_RDN[y]}
                       : {s6, serial_tx_pcs_pkg::FOUR_K7};
      if (rd_pos) begin
        s = ~s;
      end
    end else begin
      // Unbalanced sub-blocks, plus the D7 and .3 exceptions, take the complement.
      if (rd_pos && (($countones(s6) != 3) || (x == 5'h07))) begin
        s6 = ~s6;
      end
      rd6 = rd_pos ^ ($countones(s6) != 3);
      alt = (y == 3'h7) && (rd6 ? ((x == 5'h0b) || (x == 5'h0d) || (x == 5'h0e))
                                : ((x == 5'h11) || (x == 5'h12) || (x == 5'h14)));
      if (alt) begin
        s4 = serial_tx_pcs_pkg::FOUR_ALT7;
      end
      if (rd6 && (($countones(s4) != 2) || (y == 3'h3))) begin
        s4 = ~s4;
      end
      s = {s6, s4};
    end
    return {rd_pos ^ ($countones(s) != 5), reverse_bits(s, serial_tx_pcs_pkg::WORD_BITS_10)};
  endfunction

  // Widths 16 and 20 always go through the byte serializer, 10 and 20 carry raw ten-bit lanes.
  assign byte_ser  = width_sel_in[1];
  assign wide_pma  = enc_enable_in || width_sel_in[0];
  assign word_bits = wide_pma ? serial_tx_pcs_pkg::WORD_BITS_10 : serial_tx_pcs_pkg::WORD_BITS_8;

  // Bit-flip acts per fabric byte before the FIFO; bits 9:8 of each lane pass through.
  always_comb begin
    flipped = tx_data_in;
    if (bit_flip_in) begin
      for (int l = 0; l < 2; l++) begin
        for (int b = 0; b < 8; b++) begin
          flipped[10*l + b] = tx_data_in[10*l + 7 - b];
        end
      end
    end
  end

  // The logic reset also refuses fabric words so nothing is stored while the reset commas are sent.
  assign fifo_limit   = reg_mode_in ? (PTR_W+1)'(serial_tx_pcs_pkg::REG_MODE_DEPTH)
                                    : (PTR_W+1)'(DEPTH);
  assign tx_ready_out = !pcs_reset_in && (fifo_count_q < fifo_limit);
  assign push         = tx_valid_in && tx_ready_out;
  // No word leaves the FIFO while two or three sync commas are still to come, so none is lost behind them.
  assign lane_stall   = enc_enable_in && sync_q[1];
  assign pop          = tick && !pcs_reset_in && !lane_stall && (fifo_count_q != '0)
                        && (!byte_ser || !half_q);
  assign head         = fifo_mem[rd_ptr_q];

  // FIFO storage has no reset; only entries counted as occupied are ever read.
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= {tx_dispval_in, tx_force_in, tx_ctrl_in, flipped};
    end
  end

  // Pointers and occupancy; a simultaneous push and pop leaves the count alone.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q     <= '0;
      rd_ptr_q     <= '0;
      fifo_count_q <= '0;
    end else if (pcs_reset_in) begin
      wr_ptr_q     <= '0;
      rd_ptr_q     <= '0;
      fifo_count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      fifo_count_q <= fifo_count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  // Byte serializer: a wide word yields lane 0 now and lane 1 one word period later.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      half_q     <= 1'b0;
      wide_hi_q  <= 13'h0000;
      lane_d_q   <= 10'h000;
      lane_k_q   <= 1'b0;
      lane_f_q   <= 1'b0;
      lane_v_q   <= 1'b0;
      lane_vld_q <= 1'b0;
    end else if (pcs_reset_in) begin
      half_q     <= 1'b0;
      lane_vld_q <= 1'b0;
    end else if (tick && !lane_stall) begin
      if (byte_ser && half_q) begin
        // Second period: the high lane of the held word.
        {lane_v_q, lane_f_q, lane_k_q, lane_d_q} <= wide_hi_q;
        lane_vld_q <= 1'b1;
        half_q     <= 1'b0;
      end else if (pop) begin
        // First period: the low lane goes out first.
        lane_d_q   <= head[9:0];
        lane_k_q   <= head[20];
        lane_f_q   <= head[22];
        lane_v_q   <= head[24];
        wide_hi_q  <= {head[25], head[23], head[21], head[19:10]};
        lane_vld_q <= 1'b1;
        half_q     <= byte_ser;
      end else begin
        lane_vld_q <= 1'b0;
      end
    end
  end

  // Running disparity, or the override column when the override flag is set.
  assign enc_res = encode_group(lane_d_q[7:0], lane_k_q, lane_f_q ? !lane_v_q : rd_q);

  // Encoder stage. Without data, a comma keeps the link aligned; the bypass sends zeros instead.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enc_q  <= serial_tx_pcs_pkg::COMMA_RDN;
      rd_q   <= 1'b0;
      sync_q <= serial_tx_pcs_pkg::SYNC_GROUPS;
    end else if (pcs_reset_in) begin
      // Inputs are ignored and the negative-column comma repeats every period.
      enc_q  <= serial_tx_pcs_pkg::COMMA_RDN;
      rd_q   <= 1'b0;
      sync_q <= serial_tx_pcs_pkg::SYNC_GROUPS;
    end else if (tick) begin
      if (!enc_enable_in) begin
        enc_q <= lane_vld_q ? (wide_pma ? lane_d_q : {2'h0, lane_d_q[7:0]}) : 10'h000;
      end else if ((sync_q != 2'h0) || !lane_vld_q) begin
        // The reset comma still in the serializer stands ahead of these groups.
        {rd_q, enc_q} <= encode_group(serial_tx_pcs_pkg::COMMA_BYTE, 1'b1, rd_q);
        if (sync_q != 2'h0) begin
          sync_q <= sync_q - 2'h1;
        end
      end else begin
        {rd_q, enc_q} <= enc_res;
      end
    end
  end

  // Bit-level options: reversal and slip on the stream, then polarity over the word width.
  always_comb begin
    logic [19:0] pair;
    logic [3:0]  slip;
    pair     = 20'h00000;
    slip     = (slip_count_in >= word_bits) ? word_bits - 4'h1 : slip_count_in;
    rev_word = bit_rev_in ? reverse_bits(enc_q, word_bits) : enc_q;
    if (wide_pma) begin
      pair = {rev_word, prev_q};
    end else begin
      pair = {4'h0, rev_word[7:0], prev_q[7:0]};
    end
    ser_word = 10'((pair >> (word_bits - slip)));
    if (!wide_pma) begin
      ser_word[9:8] = 2'h0;
    end
    if (pol_inv_in) begin
      ser_word = ser_word ^ (wide_pma ? 10'h3ff : 10'h0ff);
    end
  end

  // Word period counter: a word lasts half its width in clocks.
  assign tick          = (cnt_q == 3'h0);
  assign word_tick_out = tick;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 3'h0;
    end else if (tick) begin
      cnt_q <= (wide_pma ? serial_tx_pcs_pkg::PAIRS_10 : serial_tx_pcs_pkg::PAIRS_8) - 3'h1;
    end else begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // Serializer: load on the tick, then two bits per clock, least significant first.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_q <= serial_tx_pcs_pkg::COMMA_RDN;
      prev_q  <= 10'h000;
    end else if (tick) begin
      shift_q <= ser_word;
      prev_q  <= rev_word;
    end else begin
      shift_q <= {2'h0, shift_q[9:2]};
    end
  end

  // Bit 0 belongs to the rising edge, bit 1 to the falling edge of the same clock.
  assign ser_bits_out = shift_q[1:0];

  // Occupancy never exceeds the storage behind it.
  AST_FIFO_CAP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fifo_count_q <= (PTR_W+1)'(DEPTH)) else $error("FIFO holds more than its depth");

  AST_REG_MODE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (reg_mode_in && $past(reg_mode_in)) |-> (fifo_count_q <= (PTR_W+1)'(1)))
    else $error("Registered mode holds two words");

  AST_LOW_BYTE_FIRST: assert property (@(posedge sys_clk_in) disable iff (rst_in || pcs_reset_in)
    (pop && byte_ser && wide_pma) |=> (lane_d_q == $past(head[9:0])) ##5 (lane_d_q == $past(head[19:10], 6)))
    else $error("Byte serializer lane order wrong");

  AST_RESET_COMMA: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pcs_reset_in |=> (enc_q == serial_tx_pcs_pkg::COMMA_RDN) && !rd_q) else $error("No comma during logic reset");

  AST_SYNC_START: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(pcs_reset_in) |-> (sync_q == 2'h3) && !rd_q) else $error("Sync count not three after release");

  AST_COMMA_FLIP: assert property (@(posedge sys_clk_in) disable iff (rst_in || pcs_reset_in)
    (tick && enc_enable_in && sync_q != 2'h0) |=> (enc_q == ($past(rd_q) ? ~serial_tx_pcs_pkg::COMMA_RDN
                                                      : serial_tx_pcs_pkg::COMMA_RDN)) && (rd_q != $past(rd_q)))
    else $error("Sync comma column or disparity wrong");

  AST_FORCE_POS: assert property (@(posedge sys_clk_in) disable iff (rst_in || pcs_reset_in)
    (tick && enc_enable_in && sync_q == 2'h0 && lane_vld_q && lane_k_q && lane_f_q && !lane_v_q
     && lane_d_q[7:0] == serial_tx_pcs_pkg::COMMA_BYTE) |=> (enc_q == ~serial_tx_pcs_pkg::COMMA_RDN))
    else $error("Forced positive column not used");

  AST_BYPASS: assert property (@(posedge sys_clk_in) disable iff (rst_in || pcs_reset_in)
    (tick && !enc_enable_in && lane_vld_q && wide_pma) |=> (enc_q == $past(lane_d_q)))
    else $error("Bypass altered word");

  AST_INVERT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (tick && pol_inv_in && !bit_rev_in && slip_count_in == 4'h0) |=> (shift_q[7:0] == ~$past(enc_q[7:0])))
    else $error("Polarity inversion missing");

  AST_LSB_FIRST: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (tick && wide_pma && $past(wide_pma)) |=> (ser_bits_out == $past(ser_word[1:0]))
    ##1 (ser_bits_out == $past(ser_word[3:2], 2)))
    else $error("Serial bits out of order");

  AST_PERIOD_TEN: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (tick && wide_pma) ##1 wide_pma[*5] |-> tick) else $error("Ten-bit word period not five clocks");

  COV_BYTE_SER: cover property (@(posedge sys_clk_in) disable iff (rst_in) pop && byte_ser);
  COV_FORCE:    cover property (@(posedge sys_clk_in) disable iff (rst_in) tick && lane_vld_q && lane_f_q);
  COV_SYNC_END: cover property (@(posedge sys_clk_in) disable iff (rst_in) $fell(sync_q != 2'h0));
  COV_SLIP:     cover property (@(posedge sys_clk_in) disable iff (rst_in) tick && slip_count_in != 4'h0);

endmodule

/* verilog/serial_tx_pcs_pkg.sv */
package serial_tx_pcs_pkg;

  // Phase-compensation FIFO capacity in words and the capacity used in registered mode.
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam int unsigned REG_MODE_DEPTH  = 1;

  // Number of comma groups sent after the logic reset is released.
  localparam logic [1:0]  SYNC_GROUPS     = 2'h3;

  // Parallel word widths on the serializer side and bit pairs per word period.
  localparam logic [3:0]  WORD_BITS_8     = 4'h8;
  localparam logic [3:0]  WORD_BITS_10    = 4'ha;
  localparam logic [2:0]  PAIRS_8         = 3'h4;
  localparam logic [2:0]  PAIRS_10        = 3'h5;

  // Comma code group, negative-disparity column, first bit sent in bit 0.
  localparam logic [9:0]  COMMA_RDN       = 10'h17c;
  localparam logic [7:0]  COMMA_BYTE      = 8'hbc;

  // Fabric word widths selected on width_sel_in.
  typedef enum logic [1:0] {
    WIDTH_8  = 2'h0,
    WIDTH_10 = 2'h1,
    WIDTH_16 = 2'h2,
    WIDTH_20 = 2'h3
  } width_sel_t;

  // Five-to-six table, negative-disparity column, written abcdei with a as the top bit.
  localparam logic [31:0][5:0] SIX_RDN = {
    6'h2b, 6'h1e, 6'h2e, 6'h0e, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3a, 6'h1a, 6'h2a, 6'h0b, 6'h32, 6'h13, 6'h23, 6'h1b,
    6'h17, 6'h1c, 6'h2c, 6'h0d, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2d, 6'h1d, 6'h27
  };

  // Three-to-four tables, negative-disparity column, written fghj with f as the top bit.
  localparam logic [7:0][3:0] FOUR_D_RDN = {4'he, 4'h6, 4'ha, 4'hd, 4'hc, 4'h5, 4'h9, 4'hb};
  localparam logic [7:0][3:0] FOUR_K_RDN = {4'h8, 4'h6, 4'ha, 4'h2, 4'h3, 4'h5, 4'h9, 4'h4};
  localparam logic [5:0]  SIX_K28         = 6'h0f;
  localparam logic [3:0]  FOUR_ALT7       = 4'h7;
  localparam logic [3:0]  FOUR_K7         = 4'h8;

endpackage
